/* File: dsps_sequencer.sv */
/*
  Phase sequencer of a dual-slope integrating converter with its
  three-wire serial port and an Avalon-MM register slave.
  Assumes all inputs, the oscillator included, are synchronous to
  ref_clk_i, and that the oscillator runs well below half its rate.
*/
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`default_nettype none
// Summary of operation
// - Timebase tick is oscillator divided by four
// - Offset null and integrate last equally long
// - Phase spans (256 - byte) x 256 ticks
// - Polarity latched at end of integrate
// - De-integrate follows integrate, ends on crossing
// - De-integrate tick count becomes result
// - Integrator clear phase precedes offset null
// - Maximum de-integrate count twice integrate count
// - Hold high halts conversion in offset null
// - Eoc driven low throughout offset null
// - Byte shifted in on rising sclk, loaded
// - Read order eoc, overrange, polarity, count
module dsps_sequencer #(
  parameter int CNT_W = 18
) (
  input  wire  logic                      ref_clk_i,
  input  wire  logic                      reset_n_i,
  input  wire  logic                      osc_i,
  input  wire  logic                      conv_hold_i,
  input  wire  logic                      cmp_i,
  input  wire  dsps_pkg::dsps_serial_type ser_i,
  output logic                            dout_o,
  output logic                            dout_oe_o,
  output logic                            eoc_n_o,
  output logic                            eoc_oe_o,
  output dsps_pkg::dsps_switch_type       sw_o,
  output dsps_pkg::dsps_phase_type        phase_o,
  input  wire  logic [4:0]                address,
  input  wire  logic                      read,
  input  wire  logic                      write,
  input  wire  logic [31:0]               writedata,
  output logic [31:0]                     readdata,
  output logic                            waitrequest,
  output logic                            irq_o
);
  import dsps_pkg::*;

  localparam int FRAME_W = HDR_BITS + CNT_W;

  function automatic logic [CNT_W-1:0] max_count(input logic [7:0] lv);
    logic [CNT_W-1:0] span;
    span = CNT_W'(9'(PHASE_SPAN) - {1'b0, lv});
    max_count = CNT_W'(span * CNT_W'(2 * GROUP_TICKS));
  endfunction

  dsps_phase_type   phase_r;
  logic             osc_q_r;
  logic [1:0]       div_r;
  logic [7:0]       tick_cnt_r;
  logic [7:0]       phase_cnt_r;
  logic [7:0]       load_val_r;
  logic [7:0]       in_shift_r;
  logic [CNT_W-1:0] deint_cnt_r;
  logic [CNT_W-1:0] res_cnt_r;
  logic             res_ovr_r;
  logic             res_pol_r;
  logic             pol_r;
  logic [FRAME_W-1:0] out_shift_r;
  logic             unshifted_r;
  logic             sclk_q_r;
  logic             rnw_q_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_en_r;
  logic             soft_hold_r;
  logic             ack_r;
  logic [31:0]      readdata_r;

  wire osc_rise    = osc_i & ~osc_q_r;
  wire tick        = osc_rise & (div_r == OSC_DIV_LAST);
  wire sclk_rise   = ser_i.sclk & ~sclk_q_r;
  wire sclk_fall   = ~ser_i.sclk & sclk_q_r;
  wire rnw_rise    = ser_i.rnw & ~rnw_q_r;
  wire hold        = conv_hold_i | soft_hold_r;
  wire restart     = hold | rnw_rise;
  wire grp_wrap    = tick & (tick_cnt_r == GROUP_LAST);
  wire phase_end   = grp_wrap & (phase_cnt_r == PHASE_LAST);
  wire in_az       = (phase_r == offset_null_phase);
  wire in_int      = (phase_r == input_integrate_phase);
  wire in_ref_deintegrate_phase     = (phase_r == ref_deintegrate_phase);
  wire in_iz       = (phase_r == integrator_clear_phase);
  wire [CNT_W-1:0] max_cnt  = max_count(load_val_r);
  wire [CNT_W-1:0] cnt_inc  = CNT_W'(deint_cnt_r + 1'b1);
  wire crossed     = (cmp_i != pol_r);
  wire cross_evt   = ~restart & in_ref_deintegrate_phase & tick & crossed;
  wire ovr_evt     = ~restart & in_ref_deintegrate_phase & tick & ~crossed
                     & (cnt_inc == max_cnt);
  wire done_evt    = cross_evt | ovr_evt;
  wire eoc_bit     = ~in_az;
  wire [7:0] preload = rnw_rise ? in_shift_r : load_val_r;
  wire [CNT_W-1:0] res_cnt_nxt = ovr_evt ? max_cnt : deint_cnt_r;
  wire bus_req     = read | write;
  wire bus_take    = bus_req & ack_r;
  wire wr_take     = write & ack_r;
  wire [IRQ_W-1:0] irq_evt = {rnw_rise, ovr_evt, done_evt};
  wire [IRQ_W-1:0] irq_clr = (wr_take && address == IRQ_CLR_OFS)
                             ? writedata[IRQ_W-1:0] : IRQ_RST;
  wire [FRAME_W-1:0] frame = {eoc_bit, res_ovr_r, res_pol_r, res_cnt_r};
  wire [FRAME_W-1:0] done_frame = {eoc_bit, ovr_evt, pol_r, res_cnt_nxt};
  wire [31:0] rd_mux =
    (address == IRQ_STAT_OFS) ? 32'(irq_stat_r) :
    (address == IRQ_EN_OFS)   ? 32'(irq_en_r)   :
    (address == RESULT_OFS)   ? 32'(frame)      :
    (address == CTRL_OFS)     ? 32'(soft_hold_r) :
    (address == PHASE_OFS)    ? 32'({load_val_r, 6'h00, phase_r}) :
                                32'h0000_0000;

  // Oscillator divider and serial edge detection
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      osc_q_r  <= 1'b0;
      div_r    <= 2'b00;
      sclk_q_r <= 1'b0;
      rnw_q_r  <= 1'b1;
    end else begin
      osc_q_r  <= osc_i;
      div_r    <= restart ? 2'b00 : 2'(div_r + osc_rise);
      sclk_q_r <= ser_i.sclk;
      rnw_q_r  <= ser_i.rnw;
    end
  end

  // Length byte input shifter and load
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      in_shift_r <= LOAD_VAL_RST;
      load_val_r <= LOAD_VAL_RST;
    end else begin
      if (!ser_i.rnw && sclk_rise) begin
        in_shift_r <= {in_shift_r[6:0], ser_i.din};
      end
      if (rnw_rise) begin
        load_val_r <= in_shift_r;
      end
    end
  end

  // Phase sequencer
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_r     <= offset_null_phase;
      tick_cnt_r  <= 8'h00;
      phase_cnt_r <= LOAD_VAL_RST;
      deint_cnt_r <= '0;
      pol_r       <= 1'b0;
    end else if (restart) begin
      phase_r     <= offset_null_phase;
      tick_cnt_r  <= 8'h00;
      phase_cnt_r <= preload;
    end else begin
      tick_cnt_r <= tick ? 8'(tick_cnt_r + 1'b1) : tick_cnt_r;
      case (phase_r)
        offset_null_phase: begin
          if (phase_end) begin
            phase_r     <= input_integrate_phase;
            phase_cnt_r <= load_val_r;
          end else if (grp_wrap) begin
            phase_cnt_r <= 8'(phase_cnt_r + 1'b1);
          end
        end
        input_integrate_phase: begin
          if (phase_end) begin
            phase_r     <= ref_deintegrate_phase;
            pol_r       <= cmp_i;
            deint_cnt_r <= '0;
            tick_cnt_r  <= 8'h00;
          end else if (grp_wrap) begin
            phase_cnt_r <= 8'(phase_cnt_r + 1'b1);
          end
        end
        ref_deintegrate_phase: begin
          if (done_evt) begin
            phase_r    <= integrator_clear_phase;
            tick_cnt_r <= 8'h00;
          end else if (tick) begin
            deint_cnt_r <= cnt_inc;
          end
        end
        integrator_clear_phase: begin
          if (grp_wrap) begin
            phase_r     <= offset_null_phase;
            phase_cnt_r <= load_val_r;
          end
        end
        default: begin
          phase_r <= offset_null_phase;
        end
      endcase
    end
  end

  // Conversion result
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      res_cnt_r <= '0;
      res_ovr_r <= 1'b0;
      res_pol_r <= 1'b0;
    end else if (done_evt) begin
      res_cnt_r <= res_cnt_nxt;
      res_ovr_r <= ovr_evt;
      res_pol_r <= pol_r;
    end
  end

  // Output shift register, eoc bit kept live until first shift
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_shift_r <= '0;
      unshifted_r <= 1'b1;
    end else if (rnw_rise || done_evt) begin
      out_shift_r <= rnw_rise ? {1'b0, frame[FRAME_W-2:0]} : done_frame;
      unshifted_r <= 1'b1;
    end else if (ser_i.rnw && sclk_fall) begin
      out_shift_r <= {out_shift_r[FRAME_W-2:0], 1'b0};
      unshifted_r <= 1'b0;
    end else if (unshifted_r && in_iz && grp_wrap) begin
      out_shift_r[FRAME_W-1] <= 1'b0;
    end else if (unshifted_r) begin
      out_shift_r[FRAME_W-1] <= eoc_bit;
    end
  end

  // Avalon-MM slave with one wait state
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_r       <= 1'b0;
      readdata_r  <= 32'h0000_0000;
      irq_en_r    <= IRQ_RST;
      soft_hold_r <= HOLD_RST;
    end else begin
      ack_r      <= bus_req & ~ack_r;
      readdata_r <= (read && !ack_r) ? rd_mux : readdata_r;
      if (wr_take && address == IRQ_EN_OFS) begin
        irq_en_r <= writedata[IRQ_W-1:0];
      end
      if (wr_take && address == CTRL_OFS) begin
        soft_hold_r <= writedata[0];
      end
    end
  end

  // Sticky events, set wins over clear
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_stat_r <= IRQ_RST;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_evt;
    end
  end

  assign waitrequest = bus_req & ~ack_r;
  assign readdata    = readdata_r;
  assign irq_o       = |(irq_stat_r & irq_en_r);
  assign dout_o      = out_shift_r[FRAME_W-1];
  assign dout_oe_o   = ser_i.rnw;
  assign eoc_n_o     = 1'b0;
  assign eoc_oe_o    = in_az;
  assign phase_o     = phase_r;
  assign sw_o        = '{offset_null: in_az, integrate: in_int,
                         deintegrate: in_ref_deintegrate_phase, clear: in_iz};

  sequence int_exit_s;
    $past(phase_r) == input_integrate_phase && !in_int;
  endsequence

  sequence clean_step_s;
    !$past(restart);
  endsequence

  eoc_tracks_az_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    eoc_oe_o == in_az && eoc_n_o == 1'b0)
    else $error("eoc not driven exactly in offset null");

  hold_forces_az_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    hold |=> in_az && tick_cnt_r == 8'h00)
    else $error("hold did not force offset null");

  az_leaves_int_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    in_az && !restart && $rose(phase_cnt_r == PHASE_LAST) |->
      !in_int [*2])
    else $error("offset null ended early");

  int_to_ref_deintegrate_phase_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    int_exit_s and clean_step_s |-> in_ref_deintegrate_phase && pol_r == $past(cmp_i))
    else $error("integrate exit wrong or polarity not latched");

  ovr_result_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ovr_evt |=> res_ovr_r && res_cnt_r == $past(max_cnt) && in_iz)
    else $error("overrange not recorded");

  cross_result_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    cross_evt |=> !res_ovr_r && res_cnt_r == $past(deint_cnt_r))
    else $error("count not stored at crossing");

  clear_to_az_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    in_iz |=> in_iz || in_az)
    else $error("clear phase left to wrong phase");

  tick_spacing_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    tick |=> !tick [*7])
    else $error("timebase ticks too close");

  load_on_rise_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    rnw_rise |=> load_val_r == $past(in_shift_r)
      && phase_cnt_r == $past(in_shift_r) && in_az)
    else $error("length byte not loaded on rise");

  frame_order_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    (rnw_rise || done_evt) |=> out_shift_r[FRAME_W-2:0] == frame[FRAME_W-2:0])
    else $error("serial frame order wrong");

  bus_answer_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    $rose(bus_req) |-> waitrequest ##1 !waitrequest)
    else $error("bus answer not after one wait state");
endmodule
`default_nettype wire

/* File: dsps_pkg.sv */
/*
  Constants, phase encoding and carrier types for the dual-slope phase
  sequencer. Assumes a single 250 MHz system clock.
*/
`default_nettype none
package dsps_pkg;
  // Timebase divides the oscillator input by four
  localparam int          OSC_DIV          = 4;
  localparam logic [1:0]  OSC_DIV_LAST     = 2'(OSC_DIV - 1);
  // Phase counter preload reference and ticks per phase step
  localparam int          PHASE_SPAN       = 256;
  localparam int          GROUP_TICKS      = 256;
  localparam logic [7:0]  GROUP_LAST       = 8'(GROUP_TICKS - 1);
  localparam logic [7:0]  PHASE_LAST       = 8'h00_FF;
  localparam logic [7:0]  LOAD_VAL_RST     = 8'h00_00;
  // Serial frame layout: eoc, overrange, polarity, count
  localparam int          HDR_BITS         = 3;
  // Register byte offsets
  localparam logic [4:0]  IRQ_STAT_OFS     = 5'h00;
  localparam logic [4:0]  IRQ_EN_OFS       = 5'h04;
  localparam logic [4:0]  IRQ_CLR_OFS      = 5'h08;
  localparam logic [4:0]  RESULT_OFS       = 5'h0C;
  localparam logic [4:0]  CTRL_OFS         = 5'h10;
  localparam logic [4:0]  PHASE_OFS        = 5'h14;
  // Interrupt bit positions
  localparam int          IRQ_DONE_BIT     = 0;
  localparam int          IRQ_OVR_BIT      = 1;
  localparam int          IRQ_LOAD_BIT     = 2;
  localparam int          IRQ_W            = 3;
  localparam logic [2:0]  IRQ_RST          = 3'h0;
  localparam logic        HOLD_RST         = 1'b0;

  // Gray coded along offset null, integrate, de-integrate, clear
  typedef enum logic [1:0] {
    offset_null_phase      = 2'b00,
    input_integrate_phase  = 2'b01,
    ref_deintegrate_phase  = 2'b11,
    integrator_clear_phase = 2'b10
  } dsps_phase_type;

  typedef struct packed {
    logic sclk;
    logic din;
    logic rnw;
  } dsps_serial_type;

  typedef struct packed {
    logic offset_null;
    logic integrate;
    logic deintegrate;
    logic clear;
  } dsps_switch_type;
endpackage
`default_nettype wire

/* File: dsps_integrator_model.sv */
/*
  Behavioural integrator and comparator in front of the sequencer.
  Assumes the switch struct from the sequencer and an osc_i that is
  synchronous to ref_clk_i.
*/
`default_nettype none
module dsps_integrator_model import dsps_pkg::*; (
  input  wire logic                      ref_clk_i,
  input  wire logic                      reset_n_i,
  input  wire logic                      osc_i,
  input  wire dsps_pkg::dsps_switch_type sw_i,
  input  wire logic signed [15:0]        vin_i,
  output logic                           cmp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic osc_q;
  logic pol_q;
  int   acc;
  assign cmp_o = (acc > 0);
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc   <= 0;
      osc_q <= 1'b0;
      pol_q <= 1'b0;
    end else begin
      osc_q <= osc_i;
      if (sw_i.integrate) begin
        pol_q <= (acc > 0);
      end
      if (sw_i.clear || sw_i.offset_null) begin
        acc <= 0;
      end else if (osc_i && !osc_q) begin
        if (sw_i.integrate) begin
          acc <= acc + int'(vin_i);
        end else if (sw_i.deintegrate) begin
          // Reference slope puts full scale at twice the integrate count
          acc <= pol_q ? acc - 256 : acc + 256;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: test_dual_slope_phase_sequencer.sv */
/*
  Self-checking bench for the phase sequencer: register bus, serial
  port and conversions against an integrator model.
  Assumes one 250 MHz clock and an oscillator at a quarter of it.
*/
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  bad_count++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module test_dual_slope_phase_sequencer import dsps_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   ref_clk_i = 1'b0;
  logic                   reset_n_i = 1'b0;
  logic                   osc       = 1'b0;
  logic                   osc_div   = 1'b0;
  logic                   hold      = 1'b1;
  logic                   cmp;
  dsps_serial_type        ser       = 3'b001;
  logic                   dout, dout_oe, eoc_n, eoc_oe, irq, waitrequest;
  dsps_switch_type        sw;
  dsps_phase_type         phase, phase_q;
  logic [4:0]             address   = '0;
  logic                   read      = 1'b0;
  logic                   write     = 1'b0;
  logic [31:0]            writedata = '0;
  logic [31:0]            readdata;
  logic signed [15:0]     vin       = 16'sh0064;
  logic                   eoc_pin;
  int                     bad_count = 0;
  int                     cmp_count = 0;
  int                     run_len   = 0;
  int                     int_len   = 0;
  int                     az_len    = 0;
  logic                   rnw_q     = 1'b1;
  assign eoc_pin = eoc_oe ? eoc_n : 1'b1;
  always #2 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    osc_div <= ~osc_div;
    if (osc_div) osc <= ~osc;
    phase_q <= phase;
    if (phase === phase_q) begin
      run_len <= run_len + 1;
    end else begin
      if (phase_q == input_integrate_phase) int_len <= run_len;
      if (phase_q == offset_null_phase) az_len <= run_len;
      run_len <= 1;
    end
    // A length byte load restarts offset null without a phase change
    rnw_q <= ser.rnw;
    if (ser.rnw && !rnw_q) run_len <= 1;
  end
  dsps_sequencer DUT (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .osc_i(osc), .conv_hold_i(hold), .cmp_i(cmp), .ser_i(ser),
    .dout_o(dout), .dout_oe_o(dout_oe), .eoc_n_o(eoc_n),
    .eoc_oe_o(eoc_oe), .sw_o(sw), .phase_o(phase), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .irq_o(irq));
  dsps_integrator_model model (.ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i), .osc_i(osc), .sw_i(sw), .vin_i(vin),
    .cmp_o(cmp));
  function automatic logic near(input logic signed [31:0] a, b, t);
    return (a - b <= t) && (b - a <= t);
  endfunction
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    address <= a;
    writedata <= wd;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge ref_clk_i);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic rchk(input logic [4:0] a, input logic [31:0] e,
                      input string nm);
    logic [31:0] d;
    bus(1'b0, a, '0, d);
    `CHK(nm, e, d)
  endtask
  task automatic ser_load(input logic [7:0] b);
    while (eoc_pin !== 1'b0) @(posedge ref_clk_i);
    for (int i = 7; i >= 0; i--) begin
      ser.rnw <= 1'b0;
      ser.din <= b[i];
      @(posedge ref_clk_i);
      ser.sclk <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      ser.sclk <= 1'b0;
      @(posedge ref_clk_i);
    end
    ser.rnw <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
  endtask
  task automatic ser_read(output logic [20:0] f);
    for (int i = 20; i >= 0; i--) begin
      @(posedge ref_clk_i);
      f[i] = dout;
      ser.sclk <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      ser.sclk <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
    end
    `CHK("dout_oe", 1'b1, dout_oe)
  endtask
  task automatic conv(input logic polarity_bit, input logic overrange_bit, input int cnt);
    int n;
    logic [31:0] d;
    logic [20:0] f;
    n = 0;
    while (irq !== 1'b1 && n < 40000) begin
      @(posedge ref_clk_i);
      n++;
    end
    `CHK("irq_done", 1'b1, irq)
    n = 0;
    while (phase !== offset_null_phase && n < 8000) begin
      @(posedge ref_clk_i);
      n++;
    end
    `CHK("eoc_pin", 1'b0, eoc_pin)
    ser_read(f);
    `CHK("eoc_bit", 1'b0, f[20])
    `CHK("ovr_bit", overrange_bit, f[19])
    `CHK("pol_bit", polarity_bit, f[18])
    `CHK("count", 1'b1, near(f[17:0], cnt, 3))
    `CHK("int_len", 1'b1, near(int_len, 4096, 8))
    `CHK("az_len", 1'b1, near(az_len, int_len, 8))
    bus(1'b0, IRQ_STAT_OFS, '0, d);
    `CHK("stat_ovr", overrange_bit, d[IRQ_OVR_BIT])
    bus(1'b0, RESULT_OFS, '0, d);
    `CHK("res_flags", {overrange_bit, polarity_bit}, d[19:18])
    `CHK("res_cnt", 1'b1, near(d[17:0], cnt, 3))
    bus(1'b1, IRQ_CLR_OFS, 32'h0000_0007, d);
    `CHK("irq_clr", 1'b0, irq)
    $display("test conversion done");
  endtask
  initial begin
    repeat (90000) @(posedge ref_clk_i);
    bad_count++;
    give_verdict();
  end
  initial begin
    logic [31:0] d;
    repeat (20) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    repeat (20) @(posedge ref_clk_i);
    `CHK("hold_phase", offset_null_phase, phase)
    hold <= 1'b0;
    rchk(IRQ_STAT_OFS, 32'h0000_0000, "stat_rst");
    rchk(IRQ_EN_OFS, 32'h0000_0000, "en_rst");
    rchk(CTRL_OFS, 32'h0000_0000, "ctrl_rst");
    rchk(5'h1C, 32'h0000_0000, "unmapped");
    bus(1'b1, IRQ_EN_OFS, 32'h0000_0007, d);
    rchk(IRQ_EN_OFS, 32'h0000_0007, "en_rw");
    rchk(IRQ_CLR_OFS, 32'h0000_0000, "clr_wo");
    $display("test registers done");
    ser_load(8'hFF);
    rchk(PHASE_OFS, 32'h0000_FF00, "load_val");
    `CHK("irq_load", 1'b1, irq)
    bus(1'b1, IRQ_EN_OFS, 32'h0000_0000, d);
    `CHK("irq_mask", 1'b0, irq)
    bus(1'b1, IRQ_CLR_OFS, 32'h0000_0004, d);
    rchk(IRQ_STAT_OFS, 32'h0000_0000, "stat_clr");
    bus(1'b1, IRQ_EN_OFS, 32'h0000_0001, d);
    $display("test load done");
    conv(1'b1, 1'b0, 100);
    vin <= -16'sd50;
    conv(1'b0, 1'b0, 50);
    vin <= 16'sd600;
    conv(1'b1, 1'b1, 512);
    vin <= 16'sd100;
    while (phase !== input_integrate_phase) @(posedge ref_clk_i);
    hold <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    `CHK("hold_az", offset_null_phase, phase)
    `CHK("hold_eoc", 1'b0, eoc_pin)
    repeat (100) @(posedge ref_clk_i);
    `CHK("hold_stay", 1'b1, sw.offset_null)
    hold <= 1'b0;
    bus(1'b1, CTRL_OFS, 32'h0000_0001, d);
    repeat (5000) @(posedge ref_clk_i);
    `CHK("soft_hold", offset_null_phase, phase)
    rchk(CTRL_OFS, 32'h0000_0001, "ctrl_rw");
    bus(1'b1, CTRL_OFS, 32'h0000_0000, d);
    $display("test hold done");
    ser_load(8'hFE);
    while (phase !== ref_deintegrate_phase) @(posedge ref_clk_i);
    @(posedge ref_clk_i);
    `CHK("int_len_fe", 1'b1, near(int_len, 8192, 8))
    `CHK("az_len_fe", 1'b1, near(az_len, 8192, 8))
    $display("test length done");
    give_verdict();
  end
endmodule
`default_nettype wire
